// ===== sfd_device.sv
// Notes on behaviour
// - Restart cycle is a check of one to two milliseconds.
// - Plateau cycle lasts 100 ms, results readable.
// - Restart mode: channel alone retries every two milliseconds.
// - Diagnostic mode starts itself on channel overload.
// - One restart first; plateau only if overload stays.
// - After plateau, keep restarting and keep results.
// - Each read re-runs plateau while fault persists.
// - Read during plateau holds play until next read.
// - Four tone periods without current: tweeter absent.
// - Tweeter control bit 7 enables, bit 6 threshold.
// - Tweeter found bits 7-4, valid while bit 3 zero.
// - Offset flags refresh continuously, also during play.
// - Simultaneous ground and supply shorts both reported; load short masked.
// - Report only faults stable over whole period.
// - Result bits 4-0, valid bit 6, clear on read.
// - Bit 4 marks overload with completed plateau cycle.
// - Host waits 200 ms to unmute, 10 ms off.
// - Clock pin high: legacy, data pin mutes, registers zero.
// - Four thermal flags, one to pin, progressive attenuation.
// - Undervoltage mutes; digital mute runs to completion.
// - Digital mute disabled by warning, bit, or diagnostic.
// - Reset: tristate, pin low, amp bit clear.
`timescale 1ns/1ns
`include "sfd_cfg.svh"
module sfd_device import sfd_pkg::*; #(
	parameter int MS_CYCLES = `SFD_MS_CYCLES
) (
	input wire logic clk_in,
	input wire logic reset_in,
	sfd_link_if.dev link,
	input wire logic enable_in,
	input wire logic por_in,
	input wire logic legacy_in,
	input wire logic legacy_mute_in,
	input wire logic [3:0] overload_in,
	input wire logic [3:0] short_gnd_in,
	input wire logic [3:0] short_vs_in,
	input wire logic [3:0] short_load_in,
	input wire logic [3:0] offset_in,
	input wire logic [3:0] tone_over_in,
	input wire logic tone_period_in,
	input wire logic tone_clip_in,
	input wire logic [3:0] thermal_warn_in,
	input wire logic thermal_low_in,
	input wire logic thermal_high_in,
	input wire logic undervolt_in,
	output logic [3:0] channel_on_out,
	output logic [3:0] plateau_out,
	output logic tristate_out,
	output logic analog_mute_out,
	output logic digital_mute_out,
	output logic tweeter_thr_out,
	output logic [6:0] atten_out
);
	logic [18:0] pin_s1_reg, pin_s2_reg;
	logic en_s, leg_s, lmute_s, lclk_s, lsel_s, lwr_s, lclk_d_reg;
	logic [4:0] laddr_s;
	logic [7:0] lwd_s, rdata_reg;
	logic access, rd_ev, wr_ev, run_rst, reg_rst, amp_on, ms_tick, fault_n_reg;
	logic [7:0] diag_gain_control_byte, amp_mute_control_byte, fault_pin_control_byte;
	logic [7:0] feature_control_byte, tweeter_check_control_byte, tweeter_result_byte;
	logic [4:0] res_reg [4];
	logic valid_reg;
	sfd_ch_state_t st_reg [4];
	logic [6:0] cnt_reg [4];
	logic [2:0] stab_reg [4];
	logic [3:0] first_reg, hold_reg;
	logic [2:0] tone_cnt_reg [4];
	logic [3:0] over_seen_reg;
	logic [6:0] att_reg;
	logic [3:0] dm_cnt_reg;
	logic dm_run_reg, am_reg;

	// Link bits settle long before the link clock edge, so a bundle sync is safe
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			lclk_d_reg <= 1'b0;
		end else begin
			pin_s1_reg <= {enable_in, legacy_in, legacy_mute_in, link.lk_clk, link.lk_sel,
				link.lk_wr, link.lk_addr, link.lk_wdata};
			pin_s2_reg <= pin_s1_reg;
			lclk_d_reg <= lclk_s;
		end
	end
	assign {en_s, leg_s, lmute_s, lclk_s, lsel_s, lwr_s, laddr_s, lwd_s} = pin_s2_reg;
	assign access = lclk_s && !lclk_d_reg && lsel_s && !leg_s;
	assign rd_ev = access && !lwr_s;
	assign wr_ev = access && lwr_s;
	assign run_rst = reset_in || !en_s || por_in;
	assign reg_rst = run_rst || leg_s;
	assign amp_on = amp_mute_control_byte[`SFD_BIT_AMP_ON] || (leg_s && en_s);

	sfd_tick #(.CYCLES(MS_CYCLES)) u_ms (
		.clk_in(clk_in),
		.reset_in(run_rst),
		.clear_in(1'b0),
		.tick_out(ms_tick)
	);

	// Permanent diagnostic never sees open load
	function automatic logic [3:0] fault_priority(input logic [2:0] s);
		fault_priority = {s[2], s[1], s[0] && !s[2] && !s[1], 1'b0};
	endfunction

	function automatic logic [7:0] read_byte(input logic [4:0] a);
		read_byte = 8'h00;
		if (a == `SFD_ADDR_DIAG_GAIN) read_byte = diag_gain_control_byte;
		if (a == `SFD_ADDR_AMP_MUTE) read_byte = amp_mute_control_byte;
		if (a == `SFD_ADDR_FAULT_PIN) read_byte = fault_pin_control_byte;
		if (a == `SFD_ADDR_FEATURE) read_byte = feature_control_byte;
		if (a == `SFD_ADDR_TWEETER_CTL) read_byte = tweeter_check_control_byte;
		if (a == `SFD_ADDR_TWEETER_RES) read_byte = tweeter_result_byte;
		if (a >= `SFD_ADDR_RESULT0 && a <= `SFD_ADDR_RESULT3) begin
			read_byte = {2'b00, offset_in[a[1:0]], res_reg[a[1:0]]};
			if (a == `SFD_ADDR_RESULT0) read_byte[7:6] = {amp_on, valid_reg};
		end
	endfunction

	always_ff @(posedge clk_in) begin
		if (reg_rst) begin
			diag_gain_control_byte <= 8'h00;
			amp_mute_control_byte <= 8'h00;
			fault_pin_control_byte <= 8'h00;
			feature_control_byte <= 8'h00;
			tweeter_check_control_byte <= 8'h00;
		end else if (wr_ev) begin
			if (laddr_s == `SFD_ADDR_DIAG_GAIN) diag_gain_control_byte <= lwd_s;
			if (laddr_s == `SFD_ADDR_AMP_MUTE) amp_mute_control_byte <= lwd_s;
			if (laddr_s == `SFD_ADDR_FAULT_PIN) fault_pin_control_byte <= lwd_s;
			if (laddr_s == `SFD_ADDR_FEATURE) feature_control_byte <= lwd_s;
			if (laddr_s == `SFD_ADDR_TWEETER_CTL) tweeter_check_control_byte <= lwd_s;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_reg <= 8'h00;
		end else if (rd_ev) begin
			rdata_reg <= read_byte(laddr_s);
		end
	end

	// Per-channel diagnostic; result clear on read comes first so a store wins
	always_ff @(posedge clk_in) begin
		if (run_rst) begin
			for (int i = 0; i < 4; i++) begin
				st_reg[i] <= SFD_CH_ACTIVE;
				cnt_reg[i] <= 7'h00;
				stab_reg[i] <= 3'h0;
				res_reg[i] <= 5'h00;
			end
			first_reg <= 4'h0;
			hold_reg <= 4'h0;
			valid_reg <= 1'b0;
		end else begin
			if (rd_ev && laddr_s == `SFD_ADDR_RESULT0) valid_reg <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				if (rd_ev && laddr_s == (`SFD_ADDR_RESULT0 | 5'(i))) res_reg[i] <= 5'h00;
				stab_reg[i] <= stab_reg[i] & {short_gnd_in[i], short_vs_in[i], short_load_in[i]};
				if (ms_tick && cnt_reg[i] != 7'h00) cnt_reg[i] <= cnt_reg[i] - 7'h01;
				unique case (st_reg[i])
					SFD_CH_ACTIVE: begin
						if (overload_in[i]) begin
							st_reg[i] <= SFD_CH_RESTART;
							cnt_reg[i] <= `SFD_RESTART_MS + 7'h01;
							first_reg[i] <= diag_gain_control_byte[`SFD_BIT_DIAG_MODE];
						end
					end
					SFD_CH_RESTART: begin
						if (ms_tick && cnt_reg[i] == 7'h01) begin
							cnt_reg[i] <= `SFD_RESTART_MS + 7'h01;
							first_reg[i] <= 1'b0;
							if (!overload_in[i]) begin
								st_reg[i] <= hold_reg[i] ? SFD_CH_HOLD : SFD_CH_ACTIVE;
							end else if (first_reg[i]) begin
								st_reg[i] <= SFD_CH_PLATEAU;
								cnt_reg[i] <= `SFD_PLATEAU_MS + 7'h01;
								stab_reg[i] <= 3'h7;
							end
						end else if (rd_ev && !first_reg[i] && overload_in[i]
							&& diag_gain_control_byte[`SFD_BIT_DIAG_EN]
							&& diag_gain_control_byte[`SFD_BIT_DIAG_MODE]) begin
							st_reg[i] <= SFD_CH_PLATEAU;
							cnt_reg[i] <= `SFD_PLATEAU_MS + 7'h01;
							stab_reg[i] <= 3'h7;
						end
					end
					SFD_CH_PLATEAU: begin
						if (rd_ev) hold_reg[i] <= 1'b1;
						if (ms_tick && cnt_reg[i] == 7'h01) begin
							st_reg[i] <= SFD_CH_RESTART;
							cnt_reg[i] <= `SFD_RESTART_MS + 7'h01;
							res_reg[i] <= {1'b1, fault_priority(stab_reg[i])};
							if (i == 0) valid_reg <= 1'b1;
						end
					end
					SFD_CH_HOLD: begin
						if (rd_ev) begin
							st_reg[i] <= SFD_CH_ACTIVE;
							hold_reg[i] <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// Tweeter check: a period pulse closes each test tone period
	always_ff @(posedge clk_in) begin
		if (reg_rst || !tweeter_check_control_byte[`SFD_BIT_TW_EN]) begin
			tweeter_result_byte <= 8'h00;
			over_seen_reg <= 4'h0;
			for (int i = 0; i < 4; i++) tone_cnt_reg[i] <= 3'h0;
		end else begin
			if (rd_ev && laddr_s == `SFD_ADDR_TWEETER_RES) tweeter_result_byte <= 8'h00;
			if (tone_clip_in) tweeter_result_byte[3] <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				over_seen_reg[i] <= tone_period_in ? 1'b0 : (over_seen_reg[i] || tone_over_in[i]);
				if (tone_period_in) begin
					if (over_seen_reg[i] || tone_over_in[i]) begin
						tone_cnt_reg[i] <= 3'h0;
						tweeter_result_byte[7 - i] <= 1'b1;
					end else if (tone_cnt_reg[i] + 3'h1 >= `SFD_TONE_PERIODS) begin
						tone_cnt_reg[i] <= `SFD_TONE_PERIODS;
						tweeter_result_byte[7 - i] <= 1'b0;
					end else begin
						tone_cnt_reg[i] <= tone_cnt_reg[i] + 3'h1;
					end
				end
			end
		end
	end

	// Attenuation moves 0.5 dB per millisecond so thermal mute stays smooth
	always_ff @(posedge clk_in) begin
		if (run_rst) begin
			att_reg <= 7'h00;
		end else if (ms_tick) begin
			if (thermal_high_in) begin
				att_reg <= (att_reg < `SFD_ATT_HIGH) ? att_reg + 7'h01 : `SFD_ATT_HIGH;
			end else if (thermal_low_in) begin
				att_reg <= (att_reg > `SFD_ATT_LOW) ? att_reg - 7'h01 : `SFD_ATT_LOW;
			end else if (att_reg != 7'h00) begin
				att_reg <= att_reg - 7'h01;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (run_rst) begin
			dm_run_reg <= 1'b0;
			dm_cnt_reg <= 4'h0;
			am_reg <= 1'b0;
		end else begin
			am_reg <= undervolt_in || (leg_s && lmute_s);
			if (!dm_run_reg) begin
				dm_cnt_reg <= 4'h0;
				if (undervolt_in && !thermal_warn_in[0] && !feature_control_byte[`SFD_BIT_DM_OFF]
					&& !(diag_gain_control_byte[`SFD_BIT_DIAG_EN] && !amp_on)) begin
					dm_run_reg <= 1'b1;
				end
			end else if (dm_cnt_reg != `SFD_DM_FULL_MS) begin
				if (ms_tick) dm_cnt_reg <= dm_cnt_reg + 4'h1;
			end else if (!undervolt_in) begin
				dm_run_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (run_rst) begin
			fault_n_reg <= 1'b0;
		end else begin
			fault_n_reg <= amp_on
				&& !(fault_pin_control_byte[`SFD_BIT_SHORT_PIN] && (hold_reg != 4'h0
				|| first_reg != 4'h0 || overload_in != 4'h0))
				&& !(!fault_pin_control_byte[`SFD_BIT_NO_TW_PIN]
				&& thermal_warn_in[fault_pin_control_byte[4:3]]);
		end
	end

	always_ff @(posedge clk_in) begin
		if (run_rst) begin
			tristate_out <= 1'b1;
			channel_on_out <= 4'h0;
			plateau_out <= 4'h0;
		end else begin
			tristate_out <= !amp_on;
			for (int i = 0; i < 4; i++) begin
				channel_on_out[i] <= amp_on && st_reg[i] == SFD_CH_ACTIVE;
				plateau_out[i] <= st_reg[i] == SFD_CH_PLATEAU;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		analog_mute_out <= !reset_in && am_reg;
		digital_mute_out <= !reset_in && dm_run_reg;
		atten_out <= reset_in ? 7'h00 : att_reg;
		tweeter_thr_out <= !reset_in && tweeter_check_control_byte[`SFD_BIT_TW_THR];
	end
	assign link.lk_rdata = rdata_reg;
	assign link.lk_fault_n = fault_n_reg;
endmodule

// ===== sfd_cfg.svh
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH
`define SFD_CLK_NS 10
`define SFD_MS_NS 1000000
`define SFD_MS_CYCLES ((`SFD_MS_NS) / (`SFD_CLK_NS))
`define SFD_RESTART_MS 7'h01
`define SFD_PLATEAU_MS 7'h64
`define SFD_TONE_PERIODS 3'h4
`define SFD_DM_FULL_MS 4'h8
`define SFD_ATT_LOW 7'h01
`define SFD_ATT_HIGH 7'h78
`define SFD_TURN_ON_MS 8'hC8
`define SFD_TURN_OFF_MS 8'h0A
`define SFD_HOST_HALF 6
`define SFD_ADDR_DIAG_GAIN 5'h00
`define SFD_ADDR_AMP_MUTE 5'h01
`define SFD_ADDR_FAULT_PIN 5'h02
`define SFD_ADDR_FEATURE 5'h03
`define SFD_ADDR_TWEETER_CTL 5'h04
`define SFD_ADDR_RESULT0 5'h10
`define SFD_ADDR_RESULT3 5'h13
`define SFD_ADDR_TWEETER_RES 5'h14
`define SFD_BIT_DIAG_EN 7
`define SFD_BIT_DIAG_MODE 6
`define SFD_BIT_AMP_ON 7
`define SFD_BIT_UNMUTE_A 3
`define SFD_BIT_UNMUTE_B 2
`define SFD_BIT_SHORT_PIN 7
`define SFD_BIT_NO_TW_PIN 5
`define SFD_BIT_DM_OFF 5
`define SFD_BIT_TW_EN 7
`define SFD_BIT_TW_THR 6
`define SFD_HREG_CMD 2'h0
`define SFD_HREG_STATUS 2'h1
`define SFD_HCMD_WR 15
`endif

// ===== sfd_pkg.sv
package sfd_pkg;
	typedef enum logic [1:0] {
		SFD_CH_ACTIVE = 2'b00,
		SFD_CH_RESTART = 2'b01,
		SFD_CH_PLATEAU = 2'b10,
		SFD_CH_HOLD = 2'b11
	} sfd_ch_state_t;
	typedef enum logic [2:0] {
		SFD_H_IDLE = 3'b000,
		SFD_H_GUARD = 3'b001,
		SFD_H_SETUP = 3'b010,
		SFD_H_HIGH = 3'b011,
		SFD_H_LOW = 3'b100
	} sfd_host_state_t;
endpackage

// ===== sfd_link_if.sv
`timescale 1ns/1ns
interface sfd_link_if;
	logic lk_clk;
	logic lk_sel;
	logic lk_wr;
	logic [4:0] lk_addr;
	logic [7:0] lk_wdata;
	logic [7:0] lk_rdata;
	logic lk_fault_n;
	modport dev (input lk_clk, lk_sel, lk_wr, lk_addr, lk_wdata, output lk_rdata, lk_fault_n);
	modport host (output lk_clk, lk_sel, lk_wr, lk_addr, lk_wdata, input lk_rdata, lk_fault_n);
endinterface

// ===== sfd_tick.sv
`timescale 1ns/1ns
module sfd_tick #(
	parameter int CYCLES = 100000
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clear_in,
	output logic tick_out
);
	localparam int W = $clog2(CYCLES) + 1;
	logic [W-1:0] cnt_reg;
	always_ff @(posedge clk_in) begin
		if (reset_in || clear_in || cnt_reg == W'(CYCLES - 1)) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + W'(1);
		end
	end
	always_ff @(posedge clk_in) begin
		tick_out <= !reset_in && !clear_in && cnt_reg == W'(CYCLES - 1);
	end
endmodule

// ===== sfd_host.sv
`timescale 1ns/1ns
`include "sfd_cfg.svh"
module sfd_host import sfd_pkg::*; #(
	parameter int MS_CYCLES = `SFD_MS_CYCLES
) (
	input wire logic clk_in,
	input wire logic reset_in,
	sfd_link_if.host link,
	input wire logic [1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);
	sfd_host_state_t st_reg;
	logic [15:0] cmd_reg;
	logic [7:0] rd_s1_reg, rd_s2_reg, rdata_reg, guard_ms_reg, need_ms_reg;
	logic flt_s1_reg, flt_s2_reg, half_tick, ms_tick, half_clr;
	logic lclk_reg, lsel_reg;
	logic busy;

	assign busy = st_reg != SFD_H_IDLE;
	assign half_clr = st_reg == SFD_H_IDLE || st_reg == SFD_H_GUARD;

	sfd_tick #(.CYCLES(`SFD_HOST_HALF)) u_half (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.clear_in(half_clr),
		.tick_out(half_tick)
	);
	sfd_tick #(.CYCLES(MS_CYCLES)) u_ms (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.clear_in(1'b0),
		.tick_out(ms_tick)
	);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rd_s1_reg <= 8'h00;
			rd_s2_reg <= 8'h00;
			flt_s1_reg <= 1'b0;
			flt_s2_reg <= 1'b0;
		end else begin
			rd_s1_reg <= link.lk_rdata;
			rd_s2_reg <= rd_s1_reg;
			flt_s1_reg <= link.lk_fault_n;
			flt_s2_reg <= flt_s1_reg;
		end
	end

	// Bus slave: answer one cycle after a request; command writes stall while busy
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0000_0000;
		end else if (!avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b1;
		end else if ((avs_read_in || avs_write_in)
			&& !(avs_write_in && avs_address_in == `SFD_HREG_CMD && busy)) begin
			avs_waitrequest_out <= 1'b0;
			avs_readdata_out <= (avs_address_in == `SFD_HREG_STATUS)
				? {21'h0, st_reg == SFD_H_GUARD, flt_s2_reg, busy, rdata_reg}
				: {16'h0000, cmd_reg};
		end
	end

	// Turn-on and turn-off spacing is enforced here, not left to software
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			guard_ms_reg <= 8'h00;
		end else if (st_reg == SFD_H_HIGH && half_tick && cmd_reg[`SFD_HCMD_WR]
			&& (cmd_reg[12:8] == `SFD_ADDR_DIAG_GAIN || cmd_reg[12:8] == `SFD_ADDR_AMP_MUTE)) begin
			guard_ms_reg <= 8'h00;
		end else if (ms_tick && guard_ms_reg != 8'hFF) begin
			guard_ms_reg <= guard_ms_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_reg <= SFD_H_IDLE;
			cmd_reg <= 16'h0000;
			need_ms_reg <= 8'h00;
			rdata_reg <= 8'h00;
			lclk_reg <= 1'b0;
			lsel_reg <= 1'b0;
		end else begin
			unique case (st_reg)
				SFD_H_IDLE: begin
					if (!avs_waitrequest_out && avs_write_in && avs_address_in == `SFD_HREG_CMD) begin
						cmd_reg <= avs_writedata_in[15:0];
						need_ms_reg <= 8'h00;
						st_reg <= SFD_H_GUARD;
						if (avs_writedata_in[`SFD_HCMD_WR]) begin
							if (avs_writedata_in[12:8] == `SFD_ADDR_AMP_MUTE
								&& (avs_writedata_in[`SFD_BIT_UNMUTE_A]
								|| avs_writedata_in[`SFD_BIT_UNMUTE_B])) begin
								need_ms_reg <= `SFD_TURN_ON_MS;
							end
							if (avs_writedata_in[12:8] == `SFD_ADDR_DIAG_GAIN
								&& !avs_writedata_in[`SFD_BIT_DIAG_EN]) begin
								need_ms_reg <= `SFD_TURN_OFF_MS;
							end
						end
					end
				end
				SFD_H_GUARD: begin
					if (guard_ms_reg >= need_ms_reg) begin
						st_reg <= SFD_H_SETUP;
						lsel_reg <= 1'b1;
					end
				end
				SFD_H_SETUP: begin
					if (half_tick) begin
						st_reg <= SFD_H_HIGH;
						lclk_reg <= 1'b1;
					end
				end
				SFD_H_HIGH: begin
					if (half_tick) begin
						st_reg <= SFD_H_LOW;
						lclk_reg <= 1'b0;
					end
				end
				SFD_H_LOW: begin
					if (half_tick) begin
						st_reg <= SFD_H_IDLE;
						lsel_reg <= 1'b0;
						if (!cmd_reg[`SFD_HCMD_WR]) rdata_reg <= rd_s2_reg;
					end
				end
			endcase
		end
	end
	assign link.lk_clk = lclk_reg;
	assign link.lk_sel = lsel_reg;
	assign link.lk_wr = cmd_reg[`SFD_HCMD_WR];
	assign link.lk_addr = cmd_reg[12:8];
	assign link.lk_wdata = cmd_reg[7:0];
endmodule

// ===== sfd_link_properties.sv
`timescale 1ns/1ns
module sfd_link_properties #(
	parameter int MS_CYCLES = 100000
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic lk_clk,
	input wire logic lk_sel,
	input wire logic lk_wr,
	input wire logic [4:0] lk_addr,
	input wire logic [7:0] lk_wdata,
	input wire logic [7:0] lk_rdata,
	input wire logic lk_fault_n
);
	logic amp_seen_reg;
	logic [31:0] gap_reg;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	// Later standby events are not tracked, so only the span up to the first amp-on is judged
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			amp_seen_reg <= 1'b0;
		end else if ($rose(lk_clk) && lk_sel && lk_wr && lk_addr == 5'h01 && lk_wdata[7]) begin
			amp_seen_reg <= 1'b1;
		end
	end
	// Starts saturated, so a write soon after reset is never judged against spacing
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			gap_reg <= 32'hFFFFFFFF;
		end else if ($rose(lk_clk) && lk_sel && lk_wr && lk_addr[4:1] == 4'h0) begin
			gap_reg <= 32'h0;
		end else if (gap_reg != 32'hFFFFFFFF) begin
			gap_reg <= gap_reg + 32'h1;
		end
	end
	a_clk_needs_sel: assert property (lk_clk |-> lk_sel)
		else $error("link clock high without select");
	a_sel_setup: assert property ($rose(lk_sel) |-> !lk_clk [*4] ##[1:4] lk_clk)
		else $error("link clock not raised in time after select");
	a_clk_high_span: assert property ($rose(lk_clk) |-> lk_clk [*5] ##[1:3] !lk_clk)
		else $error("link clock high time wrong");
	a_sel_hold: assert property ($fell(lk_clk) |-> lk_sel [*4] ##[1:4] !lk_sel)
		else $error("select released at wrong time");
	a_cmd_steady: assert property (lk_sel && $past(lk_sel) |->
		$stable(lk_addr) && $stable(lk_wr) && $stable(lk_wdata))
		else $error("command changed during access");
	a_write_keeps_rdata: assert property ($rose(lk_clk) && lk_wr |->
		($stable(lk_rdata)) [*8])
		else $error("read byte changed by a write");
	a_fault_low_reset: assert property (!amp_seen_reg |-> !lk_fault_n)
		else $error("fault pin high before amplifier on");
	a_unmute_spacing: assert property ($rose(lk_clk) && lk_sel && lk_wr &&
		lk_addr == 5'h01 && (lk_wdata[3] || lk_wdata[2]) |-> gap_reg >= 32'(200 * MS_CYCLES - 20))
		else $error("unmute too soon after turn-on");
	a_off_spacing: assert property ($rose(lk_clk) && lk_sel && lk_wr &&
		lk_addr == 5'h00 && !lk_wdata[7] |-> gap_reg >= 32'(10 * MS_CYCLES - 20))
		else $error("diagnostic disable too soon after mute");
endmodule

// ===== speaker_fault_diagnostic_sequencer_tb.sv
`timescale 1ns/1ns
module speaker_fault_diagnostic_sequencer_tb;
	localparam int MS = 20;
	logic clk_in, reset_in;
	logic enable_in = 1'b1, por_in = 1'b0, legacy_in = 1'b0, legacy_mute_in = 1'b0;
	logic [3:0] overload_in = 4'h0, short_gnd_in = 4'h0, short_vs_in = 4'h0, short_load_in = 4'h0;
	logic [3:0] offset_in = 4'h0, tone_over_in = 4'h0, thermal_warn_in = 4'h0;
	logic tone_period_in = 1'b0, tone_clip_in = 1'b0, undervolt_in = 1'b0;
	logic thermal_low_in = 1'b0, thermal_high_in = 1'b0;
	logic [3:0] channel_on_out, plateau_out;
	logic tristate_out, analog_mute_out, digital_mute_out, tweeter_thr_out;
	logic [6:0] atten_out;
	logic [1:0] avs_address_in = 2'h0;
	logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, sr;
	logic [7:0] rb;
	int error_cnt = 0, n_checks = 0;
	sfd_link_if lk();
	sfd_device #(.MS_CYCLES(MS)) i_sfd_device(.clk_in, .reset_in, .link(lk), .enable_in, .por_in,
		.legacy_in, .legacy_mute_in, .overload_in, .short_gnd_in, .short_vs_in, .short_load_in,
		.offset_in, .tone_over_in, .tone_period_in, .tone_clip_in, .thermal_warn_in,
		.thermal_low_in, .thermal_high_in, .undervolt_in, .channel_on_out, .plateau_out,
		.tristate_out, .analog_mute_out, .digital_mute_out, .tweeter_thr_out, .atten_out);
	sfd_host #(.MS_CYCLES(MS)) i_sfd_host(.clk_in, .reset_in, .link(lk), .avs_address_in,
		.avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out);
	sfd_link_properties #(.MS_CYCLES(MS)) i_sfd_link_properties(.clk_in, .reset_in,
		.lk_clk(lk.lk_clk), .lk_sel(lk.lk_sel), .lk_wr(lk.lk_wr), .lk_addr(lk.lk_addr),
		.lk_wdata(lk.lk_wdata), .lk_rdata(lk.lk_rdata), .lk_fault_n(lk.lk_fault_n));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		reset_in = 1'b1;
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic ms(input int n);
		repeat (n * MS) @(posedge clk_in);
	endtask
	task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_write_in <= w;
		avs_read_in <= !w;
		avs_writedata_in <= d;
		do begin
			@(posedge clk_in);
			t++;
		end while (avs_waitrequest_out !== 1'b0 && t < 20000);
		sr = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (t >= 20000) begin
			error_cnt++;
			$display("ERROR at %0t: bus request not answered", $time);
		end
	endtask
	// Polls spacing as well as busy: the host may hold a command back for its own delay
	task automatic dev(input logic w, input logic [4:0] a, input logic [7:0] d);
		int t;
		t = 0;
		av(2'h0, 1'b1, {16'h0, w, 2'h0, a, d});
		do begin
			av(2'h1, 1'b0, 32'h0);
			t++;
		end while ((sr[8] !== 1'b0 || sr[10] !== 1'b0) && t < 9000);
		rb = sr[7:0];
		if (t >= 9000) begin
			error_cnt++;
			$display("ERROR at %0t: link command not finished", $time);
		end
	endtask
	task automatic tones(input int n);
		repeat (n) begin
			@(posedge clk_in);
			tone_period_in <= 1'b1;
			@(posedge clk_in);
			tone_period_in <= 1'b0;
			repeat (8) @(posedge clk_in);
		end
	endtask
	task close_out;
		$display("mismatches %0d, checks %0d", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_in);
		error_cnt++;
		$display("ERROR at %0t: run did not finish", $time);
		close_out;
	end
	initial begin
		repeat (10) @(posedge clk_in);
		chk(8'({lk.lk_fault_n, tristate_out}), 8'h01);
		dev(1'b0, 5'h10, 8'h00);
		chk(8'(rb[7]), 8'h00);
		dev(1'b1, 5'h00, 8'h80);
		dev(1'b1, 5'h01, 8'h80);
		chk(8'(lk.lk_fault_n), 8'h01);
		dev(1'b0, 5'h10, 8'h00);
		chk(8'(rb[7]), 8'h01);
		dev(1'b1, 5'h01, 8'h8C);
		ms(2);
		chk(8'(channel_on_out), 8'h0F);
		overload_in <= 4'h2;
		ms(4);
		chk(8'({plateau_out, channel_on_out}), 8'h0D);
		overload_in <= 4'h0;
		ms(4);
		chk(8'(channel_on_out), 8'h0F);
		dev(1'b1, 5'h00, 8'hC0);
		overload_in <= 4'h1;
		repeat (5) @(posedge clk_in);
		overload_in <= 4'h0;
		ms(4);
		chk(8'({plateau_out, channel_on_out}), 8'h0F);
		overload_in <= 4'h1;
		short_gnd_in <= 4'h1;
		short_vs_in <= 4'h1;
		short_load_in <= 4'h1;
		ms(4);
		chk(8'(plateau_out), 8'h01);
		ms(105);
		chk(8'({plateau_out, channel_on_out}), 8'h0E);
		dev(1'b0, 5'h10, 8'h00);
		chk(8'(rb[4:0]), 8'h1C);
		ms(2);
		chk(8'(plateau_out), 8'h01);
		dev(1'b0, 5'h10, 8'h00);
		chk(8'(rb[4:0]), 8'h00);
		overload_in <= 4'h0;
		short_gnd_in <= 4'h0;
		short_vs_in <= 4'h0;
		short_load_in <= 4'h0;
		ms(105);
		chk(8'(channel_on_out), 8'h0E);
		dev(1'b0, 5'h10, 8'h00);
		chk(8'(rb[6:0]), 8'h50);
		ms(4);
		chk(8'(channel_on_out), 8'h0F);
		for (int i = 0; i < 2; i++) begin
			offset_in <= (i == 0) ? 4'h4 : 4'h0;
			ms(1);
			dev(1'b0, 5'h12, 8'h00);
			chk(8'(rb[5]), (i == 0) ? 8'h01 : 8'h00);
		end
		dev(1'b1, 5'h04, 8'hC0);
		chk(8'(tweeter_thr_out), 8'h01);
		tone_over_in <= 4'hF;
		tones(1);
		tone_over_in <= 4'h5;
		tones(5);
		dev(1'b0, 5'h14, 8'h00);
		chk(rb, 8'hA0);
		dev(1'b0, 5'h14, 8'h00);
		chk(rb, 8'h00);
		tone_clip_in <= 1'b1;
		tones(4);
		dev(1'b0, 5'h14, 8'h00);
		chk(8'(rb[3]), 8'h01);
		tone_clip_in <= 1'b0;
		thermal_warn_in <= 4'h1;
		ms(1);
		chk(8'(lk.lk_fault_n), 8'h00);
		dev(1'b1, 5'h02, 8'h08);
		chk(8'(lk.lk_fault_n), 8'h01);
		thermal_warn_in <= 4'h0;
		thermal_low_in <= 1'b1;
		ms(3);
		chk(8'(atten_out), 8'h01);
		ms(1);
		chk(8'(atten_out), 8'h01);
		thermal_high_in <= 1'b1;
		ms(125);
		chk(8'(atten_out), 8'h78);
		thermal_low_in <= 1'b0;
		thermal_high_in <= 1'b0;
		undervolt_in <= 1'b1;
		ms(1);
		chk(8'({analog_mute_out, digital_mute_out}), 8'h03);
		undervolt_in <= 1'b0;
		ms(2);
		chk(8'(digital_mute_out), 8'h01);
		ms(10);
		thermal_warn_in <= 4'h1;
		undervolt_in <= 1'b1;
		ms(1);
		chk(8'({analog_mute_out, digital_mute_out}), 8'h02);
		dev(1'b1, 5'h03, 8'h20);
		thermal_warn_in <= 4'h0;
		ms(1);
		chk(8'({analog_mute_out, digital_mute_out}), 8'h02);
		undervolt_in <= 1'b0;
		dev(1'b1, 5'h01, 8'h80);
		dev(1'b1, 5'h00, 8'h00);
		legacy_in <= 1'b1;
		legacy_mute_in <= 1'b1;
		ms(1);
		chk(8'({analog_mute_out, tweeter_thr_out}), 8'h02);
		legacy_in <= 1'b0;
		legacy_mute_in <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			dev(1'b1, 5'h01, 8'h80);
			chk(8'(lk.lk_fault_n), 8'h01);
			if (i == 0) por_in <= 1'b1;
			else enable_in <= 1'b0;
			ms(1);
			por_in <= 1'b0;
			enable_in <= 1'b1;
			ms(1);
			chk(8'({lk.lk_fault_n, tristate_out}), 8'h01);
			dev(1'b0, 5'h10, 8'h00);
			chk(8'(rb[7]), 8'h00);
		end
		close_out;
	end
endmodule
